// ---- core/dio_map.vh ----
// register map, field positions and mode codes of the drive option logic
`ifndef DIO_MAP_VH
`define DIO_MAP_VH

// word offsets (byte addresses) on the wishbone slave
`define DIO_REG_CTRL 4'h0
`define DIO_REG_STAT 4'h4
`define DIO_CTRL_RST 32'h0000_0000
`define DIO_CTRL_TOPMASK 8'h07

// control register fields
`define DIO_CF_DADR 2:0
`define DIO_CF_HEAD0 4:3
`define DIO_CF_HEAD1 6:5
`define DIO_CF_SMODE 8:7
`define DIO_CF_RSTEP 9
`define DIO_CF_RRDY 10
`define DIO_CF_RCOND 11
`define DIO_CF_RIDX 12
`define DIO_CF_AUTOHL 13
`define DIO_CF_RHL 14
`define DIO_CF_BADFACE 15
`define DIO_CF_BADRDY 16
`define DIO_CF_WPEN 17
`define DIO_CF_PHASE 19:18
`define DIO_CF_LATCHEN 20
`define DIO_CF_ACT 22:21
`define DIO_CF_HARD 23
`define DIO_CF_DIV 25:24
`define DIO_CF_LOCK 26
`define DIO_CF_USED 26:0

// status register fields
`define DIO_SF_SEL 0
`define DIO_SF_LOADED 1
`define DIO_SF_SIDE 2
`define DIO_SF_READY 3
`define DIO_SF_ACT 4
`define DIO_SF_PWR 5
`define DIO_SF_WEN 6
`define DIO_SF_LATCH 7

// select modes
`define DIO_SM_RADIAL 2'h0
`define DIO_SM_BINARY 2'h1
`define DIO_SM_SIDE 2'h2
`define DIO_SM_DIRSIDE 2'h3

// stepper power modes
`define DIO_PH_UNLOAD 2'h0
`define DIO_PH_DESEL 2'h1
`define DIO_PH_ALWAYS 2'h2

// activity indicator sources
`define DIO_ACT_SEL 2'h0
`define DIO_ACT_HL 2'h1
`define DIO_ACT_RDY 2'h2

// hard sector division
`define DIO_DIV_32 2'h0
`define DIO_DIV_16 2'h1
`define DIO_DIV_8 2'h2

`endif

// ---- core/dio_sync.v ----
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dio_sync #(
  parameter W = 8,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // pins and synchronised copy
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_ff;

  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_ff <= RST;
      o_sync <= RST;
    end else begin
      meta_ff <= i_async;
      o_sync <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ---- core/dio_secdiv.v ----
// hard sector pulse divider: passes every, every second or every fourth hole
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"
module dio_secdiv #(
  parameter CW = 5
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // hole and index events, one cycle each
  input wire i_hole,
  input wire i_index,
  input wire [1:0] i_div,
  // divided sector pulse
  output reg o_sector
);
  reg [CW-1:0] cnt_ff;
  reg pass;

  always @* begin
    case (i_div)
      `DIO_DIV_16: pass = (cnt_ff[0] == 1'b0);
      `DIO_DIV_8: pass = (cnt_ff[1:0] == 2'h0);
      default: pass = 1'b1;
    endcase
  end

  // the index restarts the count so divided sectors stay aligned to it
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cnt_ff <= {CW{1'b0}};
      o_sector <= 1'b0;
    end else begin
      o_sector <= i_hole & pass;
      if (i_index)
        cnt_ff <= {CW{1'b0}};
      else if (i_hole)
        cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ---- core/dio_core.v ----
// drive interface option logic with wishbone configuration slave
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"
module dio_core #(
  parameter HOLE_CW = 5
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset,
  // wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [3:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // host interface inputs, active low
  input wire [3:0] i_drive_sel_n,
  input wire i_step_n,
  input wire i_step_dir_n,
  input wire i_head_load_cmd_n,
  input wire i_in_use_n,
  input wire i_write_gate_n,
  // drive sensors, active high
  input wire i_drive_ready,
  input wire i_index_hole,
  input wire i_sector_hole,
  input wire i_write_prot,
  input wire i_bad_media,
  input wire i_double_face_media,
  // host interface outputs, open collector, oe low drives the line
  output reg o_ready_n,
  output reg o_ready_oe_n,
  output reg o_index_n,
  output reg o_index_oe_n,
  output reg o_sector_n,
  output reg o_sector_oe_n,
  output reg o_double_face_media_n,
  output reg o_double_face_media_oe_n,
  // drive mechanics
  output reg o_step_pulse,
  output reg o_step_dir_in,
  output reg o_head_load,
  output reg o_head_side,
  output reg o_write_en,
  output reg o_stepper_pwr,
  output reg o_activity_led,
  output reg o_door_lock
);
  // synchronised pin levels, true when asserted
  wire [3:0] sel_s;
  wire [4:0] host_s;
  wire [5:0] sens_s;
  wire step_s = host_s[0];
  wire dir_s = host_s[1];
  wire hlcmd_s = host_s[2];
  wire inuse_s = host_s[3];
  wire wgate_s = host_s[4];
  wire rdy_s = sens_s[0];
  wire idx_s = sens_s[1];
  wire hole_s = sens_s[2];
  wire wp_s = sens_s[3];
  wire bad_s = sens_s[4];
  wire dface_s = sens_s[5];

  reg [31:0] ctrl_ff;
  reg step_d_ff;
  reg idx_d_ff;
  reg hole_d_ff;
  reg sel_d_ff;
  reg inuse_latch_ff;
  reg selected;
  reg side;
  reg loaded;
  reg rdy_int;
  reg act_src;
  reg idx_ok;
  wire sec_pulse;
  wire bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  reg [31:0] stat;

  wire [1:0] smode = ctrl_ff[`DIO_CF_SMODE];
  wire [2:0] dadr = ctrl_ff[`DIO_CF_DADR];
  wire step_rise = step_s & ~step_d_ff;
  wire idx_rise = idx_s & ~idx_d_ff;
  wire hole_rise = hole_s & ~hole_d_ff;
  // step, and direction outside DIO_SM_DIRSIDE mode, are honoured when selected or radially stepped
  wire step_ok = selected | ctrl_ff[`DIO_CF_RSTEP];
  // one hold term feeds both the indicator and the door lock
  wire hold_src = inuse_s | inuse_latch_ff | act_src;
  wire ctrl_wr = bus_req & i_wb_we & (i_wb_adr == `DIO_REG_CTRL);

  // true when the select line at position pos is asserted
  function pos_hit;
    input [3:0] lines;
    input [1:0] pos;
    begin
      pos_hit = lines[pos];
    end
  endfunction

  // host lines are inverted here so everything downstream is active high
  dio_sync #(.W(4)) u_sync_sel (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async(~i_drive_sel_n),
    .o_sync(sel_s)
  );

  dio_sync #(.W(5)) u_sync_host (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({~i_write_gate_n, ~i_in_use_n, ~i_head_load_cmd_n,
              ~i_step_dir_n, ~i_step_n}),
    .o_sync(host_s)
  );

  dio_sync #(.W(6)) u_sync_sens (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_double_face_media, i_bad_media, i_write_prot,
              i_sector_hole, i_index_hole, i_drive_ready}),
    .o_sync(sens_s)
  );

  // holes reach the divider only in hard-sector mode, so soft media never pulse
  // hard sector holes
  dio_secdiv #(.CW(HOLE_CW)) u_secdiv (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_hole(hole_rise & ctrl_ff[`DIO_CF_HARD]),
    .i_index(idx_rise),
    .i_div(ctrl_ff[`DIO_CF_DIV]),
    .o_sector(sec_pulse)
  );

  // select decode and head side
  always @* begin
    side = 1'b0;
    case (smode)
      `DIO_SM_BINARY: begin
        selected = sel_s[3] & (sel_s[2:0] == dadr);
      end
      `DIO_SM_SIDE: begin
        selected = pos_hit(sel_s, ctrl_ff[`DIO_CF_HEAD0])
                 | pos_hit(sel_s, ctrl_ff[`DIO_CF_HEAD1]);
        side = pos_hit(sel_s, ctrl_ff[`DIO_CF_HEAD1]);
      end
      `DIO_SM_DIRSIDE: begin
        selected = pos_hit(sel_s, ctrl_ff[`DIO_CF_HEAD0]);
        side = dir_s;
      end
      default: begin
        selected = pos_hit(sel_s, ctrl_ff[`DIO_CF_HEAD0]);
      end
    endcase
  end

  // head load, ready and activity sources
  always @* begin
    if (ctrl_ff[`DIO_CF_AUTOHL] & ctrl_ff[`DIO_CF_RHL])
      loaded = 1'b1;
    else if (ctrl_ff[`DIO_CF_AUTOHL])
      loaded = selected;
    else
      loaded = hlcmd_s & (selected | ctrl_ff[`DIO_CF_RHL]);
    rdy_int = rdy_s & ~(ctrl_ff[`DIO_CF_BADRDY] & bad_s);
    case (ctrl_ff[`DIO_CF_ACT])
      `DIO_ACT_HL: act_src = loaded;
      `DIO_ACT_RDY: act_src = rdy_int;
      default: act_src = selected;
    endcase
    idx_ok = selected | (ctrl_ff[`DIO_CF_RIDX] & rdy_int);
    if (ctrl_ff[`DIO_CF_RCOND] & ~rdy_int)
      idx_ok = 1'b0;
  end

  // configuration register and edge history
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_ff <= `DIO_CTRL_RST;
      step_d_ff <= 1'b0;
      idx_d_ff <= 1'b0;
      hole_d_ff <= 1'b0;
    end else begin
      step_d_ff <= step_s;
      idx_d_ff <= idx_s;
      hole_d_ff <= hole_s;
      if (ctrl_wr) begin
        if (i_wb_sel[0])
          ctrl_ff[7:0] <= i_wb_dat[7:0];
        if (i_wb_sel[1])
          ctrl_ff[15:8] <= i_wb_dat[15:8];
        if (i_wb_sel[2])
          ctrl_ff[23:16] <= i_wb_dat[23:16];
        // the top byte keeps only the implemented bits, so the rest read zero
        if (i_wb_sel[3])
          ctrl_ff[31:24] <= i_wb_dat[31:24] & `DIO_CTRL_TOPMASK;
      end
    end
  end

  // sample hold at select
  // loads only as selection rises, so a long select never resamples the line
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sel_d_ff <= 1'b0;
      inuse_latch_ff <= 1'b0;
    end else begin
      sel_d_ff <= selected;
      if (~ctrl_ff[`DIO_CF_LATCHEN])
        inuse_latch_ff <= 1'b0;
      else if (selected & ~sel_d_ff)
        inuse_latch_ff <= inuse_s;
    end
  end

  // status word, one field per bit, unused bits read zero
  always @* begin
    stat = 32'h0000_0000;
    stat[`DIO_SF_SEL] = selected;
    stat[`DIO_SF_LOADED] = loaded;
    stat[`DIO_SF_SIDE] = side;
    stat[`DIO_SF_READY] = rdy_int;
    stat[`DIO_SF_ACT] = o_activity_led;
    stat[`DIO_SF_PWR] = o_stepper_pwr;
    stat[`DIO_SF_WEN] = o_write_en;
    stat[`DIO_SF_LATCH] = inuse_latch_ff;
  end

  // wishbone answers one cycle after the strobe; unmapped reads give zero
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      if (bus_req & ~i_wb_we) begin
        case (i_wb_adr)
          `DIO_REG_CTRL: o_wb_dat <= ctrl_ff;
          `DIO_REG_STAT: o_wb_dat <= stat;
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  // interface drivers and mechanics, all registered
  always @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_ready_n <= 1'b1;
      o_ready_oe_n <= 1'b1;
      o_index_n <= 1'b1;
      o_index_oe_n <= 1'b1;
      o_sector_n <= 1'b1;
      o_sector_oe_n <= 1'b1;
      o_double_face_media_n <= 1'b1;
      o_double_face_media_oe_n <= 1'b1;
      o_step_pulse <= 1'b0;
      o_step_dir_in <= 1'b0;
      o_head_load <= 1'b0;
      o_head_side <= 1'b0;
      o_write_en <= 1'b0;
      o_stepper_pwr <= 1'b0;
      o_activity_led <= 1'b0;
      o_door_lock <= 1'b0;
    end else begin
      o_ready_oe_n <= ~(selected | ctrl_ff[`DIO_CF_RRDY]);
      o_ready_n <= ~rdy_int;
      // index passes the raw hole level; only its gating depends on options
      o_index_oe_n <= ~idx_ok;
      o_index_n <= ~(idx_s & idx_ok);
      o_sector_oe_n <= ~idx_ok;
      o_sector_n <= ~(sec_pulse & idx_ok);
      o_double_face_media_oe_n <= ~selected;
      o_double_face_media_n <= ctrl_ff[`DIO_CF_BADFACE] ? ~bad_s : ~dface_s;
      o_step_pulse <= step_rise & step_ok;
      // direction doubles as side in that mode, so it then never steers
      if (step_ok & (smode != `DIO_SM_DIRSIDE))
        o_step_dir_in <= dir_s;
      o_head_load <= loaded;
      o_head_side <= side;
      o_write_en <= wgate_s & selected & ~(ctrl_ff[`DIO_CF_WPEN] & wp_s);
      case (ctrl_ff[`DIO_CF_PHASE])
        `DIO_PH_DESEL: o_stepper_pwr <= selected;
        `DIO_PH_ALWAYS: o_stepper_pwr <= 1'b1;
        default: o_stepper_pwr <= loaded;
      endcase
      o_activity_led <= hold_src;
      o_door_lock <= ctrl_ff[`DIO_CF_LOCK] & hold_src;
    end
  end
endmodule
`default_nettype wire

// ---- tb/dio_host_model.sv ----
// host receivers for the open-collector status lines
`timescale 1ns/1ps
`default_nettype none
module dio_host_model (
  // line values and enables from the drive
  input wire logic [3:0] i_val_n,
  input wire logic [3:0] i_oe_n,
  // levels seen by the host
  output logic [3:0] o_line_n
);
  // one drive per chain
  // a released line rests at the terminator level, never the last value
  assign o_line_n = i_oe_n | i_val_n;
endmodule
`default_nettype wire

// ---- tb/dio_core_sva.sv ----
// port checks of the drive option logic
`timescale 1ns/1ps
`default_nettype none
module dio_core_sva #(
  parameter HOLE_CW = 5
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // watched ports
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_step_n,
  input wire logic i_write_gate_n,
  input wire logic o_step_pulse,
  input wire logic o_write_en,
  input wire logic o_activity_led,
  input wire logic o_door_lock,
  input wire logic o_sector_n,
  input wire logic o_sector_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ack_follows_req_a:
    assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  ack_one_cycle_a:
    assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than a cycle");
  unmapped_zero_a:
    assert property (i_wb_cyc && i_wb_stb && !i_wb_we && i_wb_adr == 4'h8 && !o_wb_ack
      |=> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  step_single_a:
    assert property (o_step_pulse |=> !o_step_pulse) else $error("step pulse too long");
  step_cause_a:
    assert property (o_step_pulse |-> !$past(i_step_n, 3)) else $error("step without pin");
  write_gate_a:
    assert property (o_write_en |-> !$past(i_write_gate_n, 3)) else $error("write ungated");
  lock_led_a:
    assert property (o_door_lock |-> o_activity_led) else $error("lock without indicator");
  sector_pulse_a:
    assert property (!o_sector_oe_n && !o_sector_n |=> o_sector_n)
    else $error("sector pulse too long");
endmodule
bind dio_core dio_core_sva #(.HOLE_CW(HOLE_CW)) u_dio_core_sva (.i_clk(i_clk),
  .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_step_n(i_step_n),
  .i_write_gate_n(i_write_gate_n), .o_step_pulse(o_step_pulse), .o_write_en(o_write_en),
  .o_activity_led(o_activity_led), .o_door_lock(o_door_lock), .o_sector_n(o_sector_n),
  .o_sector_oe_n(o_sector_oe_n));
`default_nettype wire

// ---- tb/drive_interface_option_logic_test.sv ----
// directed bench for the drive option logic
`timescale 1ns/1ps
`default_nettype none
module drive_interface_option_logic_test;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  // 3:0 select, 4 step, 5 dir, 6 head load, 7 in use, 8 write gate, 14:9 sensors
  logic [14:0] p = 15'h01FF;
  wire [31:0] rdat;
  wire ack, stp, din, hl, sd, wen, pwr, led, lck;
  wire [3:0] vn, oen, ln;
  int n_mismatch = 0, comparisons = 0, nsec = 0, nstp = 0;
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    nsec <= nsec + (ln[2] ? 0 : 1);
    nstp <= nstp + (stp ? 1 : 0);
  end
  dio_core u_dio_core (.i_clk(i_clk), .i_reset(i_reset),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_drive_sel_n(p[3:0]),
    .i_step_n(p[4]), .i_step_dir_n(p[5]), .i_head_load_cmd_n(p[6]), .i_in_use_n(p[7]),
    .i_write_gate_n(p[8]), .i_drive_ready(p[9]), .i_index_hole(p[10]),
    .i_sector_hole(p[11]), .i_write_prot(p[12]), .i_bad_media(p[13]),
    .i_double_face_media(p[14]), .o_ready_n(vn[0]), .o_ready_oe_n(oen[0]),
    .o_index_n(vn[1]), .o_index_oe_n(oen[1]), .o_sector_n(vn[2]), .o_sector_oe_n(oen[2]),
    .o_double_face_media_n(vn[3]), .o_double_face_media_oe_n(oen[3]),
    .o_step_pulse(stp), .o_step_dir_in(din), .o_head_load(hl), .o_head_side(sd),
    .o_write_en(wen), .o_stepper_pwr(pwr), .o_activity_led(led), .o_door_lock(lck));
  dio_host_model u_dio_host_model (.i_val_n(vn), .i_oe_n(oen), .o_line_n(ln));
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // pins need 3 edges to reach most outputs and 4 through the sector divider or the in-use latch
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge i_clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (n >= 64) begin
      n_mismatch++;
      final_report();
    end
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic cfg(input logic [31:0] v);
    logic [31:0] q;
    wb(1'b1, 4'h0, v, q);
    tick(4);
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge i_clk);
    p[i] <= v;
    tick(4);
  endtask
  task automatic sel(input logic [3:0] v);
    @(posedge i_clk);
    p[3:0] <= v;
    tick(4);
  endtask
  initial begin
    logic [31:0] q;
    int s0;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    tick(2);
    rd(4'h0, 32'hFFFFFFFF, 32'h0);
    rd(4'h4, 32'hFFFFFFFF, 32'h0);
    wb(1'b1, 4'h0, 32'hFFFFFFFF, q);
    rd(4'h0, 32'hFFFFFFFF, 32'h07FFFFFF);
    wb(1'b1, 4'h8, 32'hFFFFFFFF, q);
    rd(4'h8, 32'hFFFFFFFF, 32'h0);
    cfg(32'h8);
    sel(4'hD);
    rd(4'h4, 32'h1, 32'h1);
    chk(led, 1'b1);
    chk(lck, 1'b0);
    sel(4'hF);
    chk(led, 1'b0);
    s0 = nstp;
    pin(5, 1'b0);
    pin(4, 1'b0);
    pin(4, 1'b1);
    chk(nstp - s0, 0);
    cfg(32'h208);
    pin(4, 1'b0);
    pin(4, 1'b1);
    chk(nstp - s0, 1);
    chk(din, 1'b1);
    pin(6, 1'b0);
    chk(hl, 1'b0);
    cfg(32'h4008);
    chk(hl, 1'b1);
    chk(pwr, 1'b1);
    pin(6, 1'b1);
    chk(hl, 1'b0);
    chk(pwr, 1'b0);
    cfg(32'h6008);
    chk(hl, 1'b1);
    cfg(32'h2008);
    chk(hl, 1'b0);
    sel(4'hD);
    chk(hl, 1'b1);
    sel(4'hF);
    $display("test step and head load done");
    pin(9, 1'b1);
    chk(ln[0], 1'b1);
    cfg(32'h408);
    chk(ln[0], 1'b0);
    cfg(32'h1808);
    pin(9, 1'b0);
    pin(10, 1'b1);
    // selected but not ready: only the conditioning keeps index off
    sel(4'hD);
    chk(ln[1], 1'b1);
    sel(4'hF);
    pin(9, 1'b1);
    chk(ln[1], 1'b0);
    pin(10, 1'b0);
    cfg(32'h8008);
    sel(4'hD);
    pin(13, 1'b1);
    chk(ln[3], 1'b0);
    pin(13, 1'b0);
    pin(14, 1'b1);
    chk(ln[3], 1'b1);
    cfg(32'h20008);
    pin(12, 1'b1);
    pin(8, 1'b0);
    chk(wen, 1'b0);
    pin(12, 1'b0);
    chk(wen, 1'b1);
    pin(8, 1'b1);
    cfg(32'h80008);
    sel(4'hF);
    chk(pwr, 1'b1);
    cfg(32'h40008);
    chk(pwr, 1'b0);
    sel(4'hD);
    chk(pwr, 1'b1);
    sel(4'hF);
    cfg(32'h10408);
    chk(ln[0], 1'b0);
    pin(13, 1'b1);
    chk(ln[0], 1'b1);
    pin(13, 1'b0);
    $display("test status lines done");
    // indicator follows ready here, so with ready off only the in-use line or its latch can hold it lit
    cfg(32'h4500008);
    pin(9, 1'b0);
    pin(7, 1'b0);
    chk(led, 1'b1);
    sel(4'hD);
    pin(7, 1'b1);
    sel(4'hF);
    chk(led, 1'b1);
    chk(lck, 1'b1);
    sel(4'hD);
    sel(4'hF);
    chk(led, 1'b0);
    pin(9, 1'b1);
    chk(led, 1'b1);
    $display("test in use done");
    for (int d = 0; d < 3; d++) begin
      cfg(32'h801008 | (d << 24));
      pin(10, 1'b1);
      pin(10, 1'b0);
      s0 = nsec;
      repeat (32) begin
        pin(11, 1'b1);
        pin(11, 1'b0);
      end
      chk(nsec - s0, 32 >> d);
    end
    cfg(32'h85);
    for (int c = 0; c < 8; c++) begin
      sel({1'b0, ~c[2:0]});
      rd(4'h4, 32'h1, c == 5);
    end
    sel(4'hA);
    rd(4'h4, 32'h1, 32'h0);
    cfg(32'h148);
    sel(4'hB);
    chk(sd, 1'b1);
    sel(4'hD);
    chk(sd, 1'b0);
    cfg(32'h188);
    chk(sd, 1'b1);
    pin(5, 1'b1);
    chk(sd, 1'b0);
    chk(din, 1'b1);
    $display("test sectors and select modes done");
    final_report();
  end
endmodule
`default_nettype wire
